/* rtl/uepc_defines.svh */
// Register selects, field positions, status codes and timing counts for the endpoint control logic.
`ifndef UEPC_DEFINES_SVH
`define UEPC_DEFINES_SVH

`define UEPC_SEL_EP1_TX      3'h0
`define UEPC_SEL_EP2_RX      3'h1
`define UEPC_SEL_EP2_TX      3'h2
`define UEPC_SEL_EP2_RX_CNT  3'h3
`define UEPC_SEL_EP2_TX_CNT  3'h4

`define UEPC_CTRL_RESET      8'h00
`define UEPC_CNT_RESET       7'h00
`define UEPC_DONE_BIT        3
`define UEPC_TOGGLE_BIT      2
`define UEPC_STAT_HI         1
`define UEPC_STAT_LO         0
`define UEPC_REGIME_HI       7
`define UEPC_REGIME_LO       6

`define UEPC_STAT_DISABLED   2'h0
`define UEPC_STAT_STALL      2'h1
`define UEPC_STAT_NAK        2'h2
`define UEPC_STAT_VALID      2'h3

`define UEPC_REGIME_NORMAL   2'h0
`define UEPC_REGIME_UPLOAD   2'h1
`define UEPC_REGIME_DOWNLOAD 2'h2

`define UEPC_EP1             2'h1
`define UEPC_EP2             2'h2

`define UEPC_CLK_NS          40
`define UEPC_ANS_TIMEOUT_NS  800
`define UEPC_ANS_TIMEOUT_CYC ((`UEPC_ANS_TIMEOUT_NS) / (`UEPC_CLK_NS))

`endif

/* rtl/uepc_pkg.sv */
// Types shared by both ends of the endpoint link.
package uepc_pkg;

  typedef enum logic [2:0] {
    UEPC_ANS_NONE,
    UEPC_ANS_ACK,
    UEPC_ANS_NAK,
    UEPC_ANS_STALL,
    UEPC_ANS_DATA
  } uepc_ans_t;

  typedef enum logic [1:0] {
    UEPC_DEV_IDLE,
    UEPC_DEV_WAIT_HS
  } uepc_dev_state_t;

  typedef enum logic [1:0] {
    UEPC_HOST_IDLE,
    UEPC_HOST_ANS,
    UEPC_HOST_HS
  } uepc_host_state_t;

endpackage : uepc_pkg

/* rtl/uepc_link_if.sv */
// Transaction-level link between the host end and the device end.
`timescale 1ns/100ps
interface uepc_link_if;
  logic                tok_valid;
  logic                tok_in;
  logic [1:0]          tok_ep;
  logic                tok_pid1;
  logic [6:0]          tok_len;
  logic                tok_ok;
  logic                ans_valid;
  uepc_pkg::uepc_ans_t ans_code;
  logic                ans_pid1;
  logic [6:0]          ans_len;
  logic                hs_valid;
  logic                hs_ack;

  modport host (output tok_valid, tok_in, tok_ep, tok_pid1, tok_len, tok_ok, hs_valid, hs_ack,
                input ans_valid, ans_code, ans_pid1, ans_len);
  modport dev  (input tok_valid, tok_in, tok_ep, tok_pid1, tok_len, tok_ok, hs_valid, hs_ack,
                output ans_valid, ans_code, ans_pid1, ans_len);
endinterface : uepc_link_if

/* rtl/uepc_host.sv */
// Host end: issues tokens and data packets, collects answers and returns handshakes.
`timescale 1ns/100ps
`include "uepc_defines.svh"
module uepc_host (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Link.
  uepc_link_if.host                link,
  // Command side.
  input  wire logic                cmd_valid,
  input  wire logic                cmd_in,
  input  wire logic [1:0]          cmd_ep,
  input  wire logic                cmd_pid1,
  input  wire logic [6:0]          cmd_len,
  input  wire logic                cmd_ok,
  input  wire logic                cmd_ack,
  output logic                     cmd_ready,
  // Result side.
  output logic                     res_valid,
  output uepc_pkg::uepc_ans_t      res_code,
  output logic                     res_pid1,
  output logic [6:0]               res_len
);

  localparam logic [7:0] TIMEOUT = 8'(`UEPC_ANS_TIMEOUT_CYC);

  uepc_pkg::uepc_host_state_t state_r;
  logic [7:0]                 wait_r;
  logic                       ack_r;

  wire logic take = (state_r == uepc_pkg::UEPC_HOST_IDLE) && cmd_valid;
  wire logic late = (wait_r == TIMEOUT);
  wire logic need_hs = link.ans_valid && (link.ans_code == uepc_pkg::UEPC_ANS_DATA);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r        <= uepc_pkg::UEPC_HOST_IDLE;
      wait_r         <= 8'h00;
      ack_r          <= 1'b0;
      cmd_ready      <= 1'b0;
      res_valid      <= 1'b0;
      res_code       <= uepc_pkg::UEPC_ANS_NONE;
      res_pid1       <= 1'b0;
      res_len        <= 7'h00;
      link.tok_valid <= 1'b0;
      link.tok_in    <= 1'b0;
      link.tok_ep    <= 2'h0;
      link.tok_pid1  <= 1'b0;
      link.tok_len   <= 7'h00;
      link.tok_ok    <= 1'b0;
      link.hs_valid  <= 1'b0;
      link.hs_ack    <= 1'b0;
    end else begin
      link.tok_valid <= take;
      link.hs_valid  <= 1'b0;
      res_valid      <= 1'b0;
      cmd_ready      <= (state_r == uepc_pkg::UEPC_HOST_IDLE) && !cmd_valid;
      case (state_r)
        uepc_pkg::UEPC_HOST_IDLE: begin
          wait_r <= 8'h00;
          if (take) begin
            link.tok_in   <= cmd_in;
            link.tok_ep   <= cmd_ep;
            link.tok_pid1 <= cmd_pid1;
            link.tok_len  <= cmd_len;
            link.tok_ok   <= cmd_ok;
            ack_r         <= cmd_ack;
            state_r       <= uepc_pkg::UEPC_HOST_ANS;
          end
        end
        uepc_pkg::UEPC_HOST_ANS: begin
          wait_r <= wait_r + 8'h01;
          if (link.ans_valid || late) begin
            res_valid <= 1'b1;
            res_code  <= link.ans_valid ? link.ans_code : uepc_pkg::UEPC_ANS_NONE;
            res_pid1  <= link.ans_pid1;
            res_len   <= link.ans_len;
            state_r   <= need_hs ? uepc_pkg::UEPC_HOST_HS : uepc_pkg::UEPC_HOST_IDLE;
          end
        end
        uepc_pkg::UEPC_HOST_HS: begin
          link.hs_valid <= 1'b1;
          link.hs_ack   <= ack_r;
          state_r       <= uepc_pkg::UEPC_HOST_IDLE;
        end
        default: state_r <= uepc_pkg::UEPC_HOST_IDLE;
      endcase
    end
  end

endmodule : uepc_host

/* rtl/uepc_device.sv */
// Device end: endpoint 1 transmit and endpoint 2 receive control with upload and download regimes.
//
// What this block does
// - USB reset clears low three control bits.
// - Good IN completion sets endpoint one done.
// - Transmit toggle flips only on host ACK.
// - Software may overwrite all three data toggles.
// - Transmit status: disabled, stall, NAK, valid.
// - Good transmit forces transmit status to NAK.
// - Software-written regime field picks endpoint two mode.
// - Software preloads receive size, valid, before download.
// - Software preloads transmit size, NAK, before upload.
// - Download OUTs run in hardware, done flag only on short packet.
// - Download rearms receive status when buffer ready.
// - Short download packet ends regime, flags, NAKs.
// - Download leaves endpoint two IN unchanged.
// - Upload runs IN in hardware, OUT unchanged.
// - Good reception outside download sets endpoint two done.
// - Receive toggle flips on matching good packet.
// - Receive status: disabled, stall, NAK, valid.
// - Good reception forces receive status to NAK.
// - Receive status locked against writes during download.
// - Regime neighbour bits five, four read zero.
// - Transmit status locked against writes during upload.
// - Receive counter keeps size minus bytes received.
// - Transmit counter sets bytes sent per IN.
`timescale 1ns/100ps
`include "uepc_defines.svh"
module uepc_device (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Link.
  uepc_link_if.dev        link,
  // USB reset sources.
  input  wire logic       usb_reset,
  input  wire logic       forced_usb_reset,
  // Register port.
  input  wire logic       reg_wr,
  input  wire logic [2:0] reg_sel,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      endpoint_one_transmit_control,
  output logic [7:0]      endpoint_two_receive_control,
  output logic [7:0]      endpoint_two_transmit_control,
  output logic [6:0]      ep2_receive_counter,
  output logic [6:0]      ep2_transmit_counter,
  // Endpoint 1 packet length.
  input  wire logic [6:0] ep1_tx_len,
  // Coprocessor buffer handshake.
  output logic            cop_req,
  input  wire logic       cop_ack
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  uepc_pkg::uepc_dev_state_t state_r, state_nxt;
  uepc_pkg::uepc_ans_t       ans_code_r, ans_code_nxt;
  logic                      pend_ep2_r, pend_ep2_nxt, cop_req_r, cop_req_nxt;
  logic                      ans_valid_r, ans_valid_nxt, ans_pid1_r, ans_pid1_nxt;
  logic                      ep1_done_r, ep1_done_nxt, ep1_tog_r, ep1_tog_nxt;
  logic                      rx_done_r, rx_done_nxt, rx_tog_r, rx_tog_nxt;
  logic                      tx_done_r, tx_done_nxt, tx_tog_r, tx_tog_nxt;
  logic [1:0]                ep1_stat_r, ep1_stat_nxt, regime_r, regime_nxt;
  logic [1:0]                rx_stat_r, rx_stat_nxt, tx_stat_r, tx_stat_nxt;
  logic [6:0]                rx_cnt_r, rx_cnt_nxt, rx_max_r, rx_max_nxt;
  logic [6:0]                tx_cnt_r, tx_cnt_nxt, ans_len_r, ans_len_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding.
  wire logic wr_ep1    = reg_wr && (reg_sel == `UEPC_SEL_EP1_TX);
  wire logic wr_rx     = reg_wr && (reg_sel == `UEPC_SEL_EP2_RX);
  wire logic wr_tx     = reg_wr && (reg_sel == `UEPC_SEL_EP2_TX);
  wire logic wr_rx_cnt = reg_wr && (reg_sel == `UEPC_SEL_EP2_RX_CNT);
  wire logic wr_tx_cnt = reg_wr && (reg_sel == `UEPC_SEL_EP2_TX_CNT);
  wire logic [1:0] wr_stat = reg_wdata[`UEPC_STAT_HI:`UEPC_STAT_LO];
  wire logic [1:0] wr_regime = reg_wdata[`UEPC_REGIME_HI:`UEPC_REGIME_LO];
  wire logic in_upload   = (regime_r == `UEPC_REGIME_UPLOAD);
  wire logic in_download = (regime_r == `UEPC_REGIME_DOWNLOAD);
  wire logic any_reset   = usb_reset || forced_usb_reset;
  wire logic idle_tok    = (state_r == uepc_pkg::UEPC_DEV_IDLE) && link.tok_valid;
  wire logic tok_ep1_in  = idle_tok && link.tok_in && (link.tok_ep == `UEPC_EP1);
  wire logic tok_ep2_in  = idle_tok && link.tok_in && (link.tok_ep == `UEPC_EP2);
  wire logic tok_ep2_out = idle_tok && !link.tok_in && (link.tok_ep == `UEPC_EP2);
  wire logic out_fits    = link.tok_ok && (link.tok_len <= rx_cnt_r);
  wire logic out_match   = (link.tok_pid1 == rx_tog_r);
  wire logic out_short   = (link.tok_len < rx_max_r);
  wire logic cop_done    = cop_req_r && cop_ack;
  wire logic hs_taken    = (state_r == uepc_pkg::UEPC_DEV_WAIT_HS) && link.hs_valid;

  // Maps an endpoint status to the answer for a token.
  function automatic uepc_pkg::uepc_ans_t stat_answer(input logic [1:0] stat);
    case (stat)
      `UEPC_STAT_STALL: stat_answer = uepc_pkg::UEPC_ANS_STALL;
      `UEPC_STAT_NAK:   stat_answer = uepc_pkg::UEPC_ANS_NAK;
      `UEPC_STAT_VALID: stat_answer = uepc_pkg::UEPC_ANS_DATA;
      default:          stat_answer = uepc_pkg::UEPC_ANS_NONE;
    endcase
  endfunction : stat_answer

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic; hardware events are applied after software writes so they win.
  always_comb begin
    state_nxt     = state_r;
    pend_ep2_nxt  = pend_ep2_r;
    ep1_done_nxt  = ep1_done_r;
    ep1_tog_nxt   = ep1_tog_r;
    ep1_stat_nxt  = ep1_stat_r;
    regime_nxt    = regime_r;
    rx_done_nxt   = rx_done_r;
    rx_tog_nxt    = rx_tog_r;
    rx_stat_nxt   = rx_stat_r;
    tx_done_nxt   = tx_done_r;
    tx_tog_nxt    = tx_tog_r;
    tx_stat_nxt   = tx_stat_r;
    rx_cnt_nxt    = rx_cnt_r;
    rx_max_nxt    = rx_max_r;
    tx_cnt_nxt    = tx_cnt_r;
    cop_req_nxt   = cop_req_r;
    ans_valid_nxt = 1'b0;
    ans_code_nxt  = ans_code_r;
    ans_pid1_nxt  = ans_pid1_r;
    ans_len_nxt   = ans_len_r;
    if (wr_ep1) begin
      ep1_done_nxt = ep1_done_r & reg_wdata[`UEPC_DONE_BIT];
      ep1_tog_nxt  = reg_wdata[`UEPC_TOGGLE_BIT];
      ep1_stat_nxt = wr_stat;
    end
    if (wr_rx) begin
      regime_nxt  = wr_regime;
      rx_done_nxt = rx_done_r & reg_wdata[`UEPC_DONE_BIT];
      rx_tog_nxt  = reg_wdata[`UEPC_TOGGLE_BIT];
      if (!in_download) begin
        rx_stat_nxt = wr_stat;
      end
      if (wr_regime == `UEPC_REGIME_UPLOAD && !in_upload) begin
        cop_req_nxt = 1'b1;
      end
    end
    if (wr_tx) begin
      tx_done_nxt = tx_done_r & reg_wdata[`UEPC_DONE_BIT];
      tx_tog_nxt  = reg_wdata[`UEPC_TOGGLE_BIT];
      if (!in_upload) begin
        tx_stat_nxt = wr_stat;
      end
    end
    if (wr_rx_cnt) begin
      rx_cnt_nxt = reg_wdata[6:0];
      rx_max_nxt = reg_wdata[6:0];
    end
    if (wr_tx_cnt) begin
      tx_cnt_nxt = reg_wdata[6:0];
    end
    if (cop_done) begin
      cop_req_nxt = 1'b0;
      if (in_download) begin
        rx_stat_nxt = `UEPC_STAT_VALID;
        rx_cnt_nxt  = rx_max_r;
      end else if (in_upload) begin
        tx_stat_nxt = `UEPC_STAT_VALID;
      end
    end
    if (tok_ep1_in) begin
      ans_code_nxt  = stat_answer(ep1_stat_r);
      ans_valid_nxt = (ep1_stat_r != `UEPC_STAT_DISABLED);
      ans_pid1_nxt  = ep1_tog_r;
      ans_len_nxt   = ep1_tx_len;
      if (ep1_stat_r == `UEPC_STAT_VALID) begin
        state_nxt    = uepc_pkg::UEPC_DEV_WAIT_HS;
        pend_ep2_nxt = 1'b0;
      end
    end
    if (tok_ep2_in) begin
      ans_code_nxt  = stat_answer(tx_stat_r);
      ans_valid_nxt = (tx_stat_r != `UEPC_STAT_DISABLED);
      ans_pid1_nxt  = tx_tog_r;
      ans_len_nxt   = tx_cnt_r;
      if (tx_stat_r == `UEPC_STAT_VALID) begin
        state_nxt    = uepc_pkg::UEPC_DEV_WAIT_HS;
        pend_ep2_nxt = 1'b1;
      end
    end
    if (tok_ep2_out) begin
      ans_code_nxt  = stat_answer(rx_stat_r);
      ans_valid_nxt = (rx_stat_r != `UEPC_STAT_DISABLED) && link.tok_ok;
      ans_len_nxt   = 7'h00;
      if (rx_stat_r == `UEPC_STAT_VALID) begin
        ans_code_nxt  = uepc_pkg::UEPC_ANS_ACK;
        ans_valid_nxt = out_fits;
        if (out_fits && out_match) begin
          rx_tog_nxt  = !rx_tog_r;
          rx_cnt_nxt  = rx_cnt_r - link.tok_len;
          rx_stat_nxt = `UEPC_STAT_NAK;
          if (in_download && out_short) begin
            regime_nxt  = `UEPC_REGIME_NORMAL;
            rx_done_nxt = 1'b1;
          end else if (in_download) begin
            cop_req_nxt = 1'b1;
          end else begin
            rx_done_nxt = 1'b1;
          end
        end
      end
    end
    if (hs_taken) begin
      state_nxt = uepc_pkg::UEPC_DEV_IDLE;
      if (link.hs_ack && pend_ep2_r) begin
        tx_tog_nxt  = !tx_tog_r;
        tx_stat_nxt = `UEPC_STAT_NAK;
        if (in_upload) begin
          cop_req_nxt = 1'b1;
        end else begin
          tx_done_nxt = 1'b1;
        end
      end else if (link.hs_ack) begin
        ep1_tog_nxt  = !ep1_tog_r;
        ep1_stat_nxt = `UEPC_STAT_NAK;
        ep1_done_nxt = 1'b1;
      end
    end
    if (any_reset) begin
      state_nxt    = uepc_pkg::UEPC_DEV_IDLE;
      ep1_tog_nxt  = 1'b0;
      ep1_stat_nxt = `UEPC_STAT_DISABLED;
      rx_tog_nxt   = 1'b0;
      rx_stat_nxt  = `UEPC_STAT_DISABLED;
      tx_tog_nxt   = 1'b0;
      tx_stat_nxt  = `UEPC_STAT_DISABLED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r     <= uepc_pkg::UEPC_DEV_IDLE;
      {pend_ep2_r, cop_req_r, ans_valid_r, ans_pid1_r} <= 4'h0;
      {ep1_done_r, ep1_tog_r, ep1_stat_r} <= 4'(`UEPC_CTRL_RESET);
      {regime_r, rx_done_r, rx_tog_r, rx_stat_r} <= 6'h00;
      {tx_done_r, tx_tog_r, tx_stat_r} <= 4'h0;
      {rx_cnt_r, rx_max_r, tx_cnt_r} <= {3{`UEPC_CNT_RESET}};
      ans_code_r  <= uepc_pkg::UEPC_ANS_NONE;
      ans_len_r   <= 7'h00;
    end else begin
      state_r     <= state_nxt;
      {pend_ep2_r, cop_req_r, ans_valid_r, ans_pid1_r} <= {pend_ep2_nxt, cop_req_nxt, ans_valid_nxt, ans_pid1_nxt};
      {ep1_done_r, ep1_tog_r, ep1_stat_r} <= {ep1_done_nxt, ep1_tog_nxt, ep1_stat_nxt};
      {regime_r, rx_done_r, rx_tog_r, rx_stat_r} <= {regime_nxt, rx_done_nxt, rx_tog_nxt, rx_stat_nxt};
      {tx_done_r, tx_tog_r, tx_stat_r} <= {tx_done_nxt, tx_tog_nxt, tx_stat_nxt};
      {rx_cnt_r, rx_max_r, tx_cnt_r} <= {rx_cnt_nxt, rx_max_nxt, tx_cnt_nxt};
      ans_code_r  <= ans_code_nxt;
      ans_len_r   <= ans_len_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign endpoint_one_transmit_control = {4'h0, ep1_done_r, ep1_tog_r, ep1_stat_r};
  assign endpoint_two_receive_control  = {regime_r, 2'h0, rx_done_r, rx_tog_r, rx_stat_r};
  assign endpoint_two_transmit_control = {4'h0, tx_done_r, tx_tog_r, tx_stat_r};
  assign ep2_receive_counter  = rx_cnt_r;
  assign ep2_transmit_counter = tx_cnt_r;
  assign cop_req              = cop_req_r;
  assign link.ans_valid       = ans_valid_r;
  assign link.ans_code        = ans_code_r;
  assign link.ans_pid1        = ans_pid1_r;
  assign link.ans_len         = ans_len_r;

endmodule : uepc_device

/* test/uepc_chk_sva.sv */
// Assertions on the link between the host end and the device end.
`timescale 1ns/100ps
module uepc_chk (
  // Clock and reset.
  input wire logic                clk,
  input wire logic                reset_n,
  // Token side.
  input wire logic                tok_valid,
  input wire logic                tok_in,
  input wire logic [1:0]          tok_ep,
  input wire logic                tok_pid1,
  input wire logic [6:0]          tok_len,
  input wire logic                tok_ok,
  // Answer side.
  input wire logic                ans_valid,
  input wire uepc_pkg::uepc_ans_t ans_code,
  input wire logic                ans_pid1,
  input wire logic [6:0]          ans_len,
  input wire logic                hs_valid,
  input wire logic                hs_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Tracks the last endpoint 1 data packet and whether the host acknowledged it.
  logic seen_r;
  logic pid_r;
  logic ack_r;
  wire  ep1_data = ans_valid && ans_code == uepc_pkg::UEPC_ANS_DATA && tok_ep == 2'h1;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seen_r <= 1'b0;
      pid_r  <= 1'b0;
      ack_r  <= 1'b0;
    end else if (ep1_data) begin
      seen_r <= 1'b1;
      pid_r  <= ans_pid1;
      ack_r  <= 1'b0;
    end else if (hs_valid && tok_ep == 2'h1) begin
      ack_r  <= hs_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_ANS_PULSE: assert property (ans_valid |=> !ans_valid)
    else $error("answer pulse longer than one cycle");
  AST_ANS_CAUSE: assert property (ans_valid |-> $past(tok_valid))
    else $error("answer without a token one cycle before");
  AST_EP1_OUT: assert property (tok_valid && !tok_in && tok_ep == 2'h1 |=> !ans_valid)
    else $error("answer to an OUT on the transmit-only endpoint");
  AST_BAD_OUT: assert property (tok_valid && !tok_in && !tok_ok |=> !ans_valid)
    else $error("answer to a damaged OUT packet");
  AST_IN_KIND: assert property (tok_valid && tok_in |=> !ans_valid || ans_code inside
    {uepc_pkg::UEPC_ANS_DATA, uepc_pkg::UEPC_ANS_NAK, uepc_pkg::UEPC_ANS_STALL})
    else $error("wrong answer kind to an IN token");
  AST_OUT_KIND: assert property (tok_valid && !tok_in |=> !ans_valid || ans_code inside
    {uepc_pkg::UEPC_ANS_ACK, uepc_pkg::UEPC_ANS_NAK, uepc_pkg::UEPC_ANS_STALL})
    else $error("wrong answer kind to an OUT token");
  AST_HS_GAP: assert property (ans_valid && ans_code == uepc_pkg::UEPC_ANS_DATA |=> !hs_valid ##1 hs_valid)
    else $error("handshake not two cycles after a data answer");
  AST_EP1_PID: assert property (ep1_data && seen_r |-> ans_pid1 == (pid_r ^ ack_r))
    else $error("transmit toggle moved without an acknowledge");
endmodule : uepc_chk

/* test/tb_usb_ep1_tx_ep2_rx_ctrl.sv */
// Self-checking bench joining the host end and the device end of the endpoint link.
`timescale 1ns/100ps
module tb_usb_ep1_tx_ep2_rx_ctrl;
  logic                clk       = 1'b0;
  logic                reset_n   = 1'b0;
  logic                usb_rst   = 1'b0;
  logic                frc_rst   = 1'b0;
  logic                reg_wr    = 1'b0;
  logic [2:0]          reg_sel   = 3'h0;
  logic [7:0]          reg_wdata = 8'h00;
  logic [6:0]          ep1_len   = 7'h05;
  logic                cop_ack   = 1'b0;
  logic                cmd_valid = 1'b0;
  logic                cmd_in    = 1'b0;
  logic [1:0]          cmd_ep    = 2'h0;
  logic                cmd_pid1  = 1'b0;
  logic [6:0]          cmd_len   = 7'h00;
  logic                cmd_ok    = 1'b0;
  logic                cmd_ack   = 1'b0;
  logic                cmd_ready;
  logic                res_valid;
  logic                res_pid1;
  logic                cop_req;
  uepc_pkg::uepc_ans_t res_code;
  logic [6:0]          res_len;
  logic [6:0]          rx_cnt;
  logic [6:0]          tx_cnt;
  logic [7:0]          ep1_ctl;
  logic [7:0]          rx_ctl;
  logic [7:0]          tx_ctl;
  int                  err_total = 0;
  int                  tests_run = 0;
  int                  cycles    = 0;
  uepc_pkg::uepc_ans_t in_ans [4] = '{uepc_pkg::UEPC_ANS_NONE, uepc_pkg::UEPC_ANS_STALL,
                                      uepc_pkg::UEPC_ANS_NAK, uepc_pkg::UEPC_ANS_DATA};
  uepc_pkg::uepc_ans_t out_ans [4] = '{uepc_pkg::UEPC_ANS_NONE, uepc_pkg::UEPC_ANS_STALL,
                                       uepc_pkg::UEPC_ANS_NAK, uepc_pkg::UEPC_ANS_ACK};

  uepc_link_if link ();

  uepc_host uepc_host_inst (.clk(clk), .reset_n(reset_n), .link(link), .cmd_valid(cmd_valid),
    .cmd_in(cmd_in), .cmd_ep(cmd_ep), .cmd_pid1(cmd_pid1), .cmd_len(cmd_len), .cmd_ok(cmd_ok),
    .cmd_ack(cmd_ack), .cmd_ready(cmd_ready), .res_valid(res_valid), .res_code(res_code),
    .res_pid1(res_pid1), .res_len(res_len));

  uepc_device uepc_device_inst (.clk(clk), .reset_n(reset_n), .link(link), .usb_reset(usb_rst),
    .forced_usb_reset(frc_rst), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .endpoint_one_transmit_control(ep1_ctl), .endpoint_two_receive_control(rx_ctl),
    .endpoint_two_transmit_control(tx_ctl), .ep2_receive_counter(rx_cnt),
    .ep2_transmit_counter(tx_cnt), .ep1_tx_len(ep1_len), .cop_req(cop_req), .cop_ack(cop_ack));

  uepc_chk uepc_chk_inst (.clk(clk), .reset_n(reset_n), .tok_valid(link.tok_valid),
    .tok_in(link.tok_in), .tok_ep(link.tok_ep), .tok_pid1(link.tok_pid1), .tok_len(link.tok_len),
    .tok_ok(link.tok_ok), .ans_valid(link.ans_valid), .ans_code(link.ans_code),
    .ans_pid1(link.ans_pid1), .ans_len(link.ans_len), .hs_valid(link.hs_valid), .hs_ack(link.hs_ack));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, cycle ceiling and shared tasks.
  always #20 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic ck(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : ck

  task automatic wr(input logic [2:0] sel, input logic [7:0] data);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_sel   <= sel;
    reg_wdata <= data;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic cop();
    @(posedge clk);
    cop_ack <= 1'b1;
    @(posedge clk);
    cop_ack <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : cop

  // For IN tokens pid and len give the expected data PID and length.
  task automatic xf(input logic in, input logic [1:0] ep, input logic pid, input logic [6:0] len,
                    input logic ok, input logic ack, input uepc_pkg::uepc_ans_t code);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_in    <= in;
    cmd_ep    <= ep;
    cmd_pid1  <= pid;
    cmd_len   <= len;
    cmd_ok    <= ok;
    cmd_ack   <= ack;
    n = 0;
    do @(negedge clk); while (cmd_ready !== 1'b1 && ++n < 40);
    ck("ready", {7'h00, cmd_ready}, 8'h01);
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do @(negedge clk); while (res_valid !== 1'b1 && ++n < 40);
    ck("result", {7'h00, res_valid}, 8'h01);
    ck("answer", 8'(res_code), 8'(code));
    if (in && code == uepc_pkg::UEPC_ANS_DATA) begin
      ck("data pid", {7'h00, res_pid1}, {7'h00, pid});
      ck("data len", {1'b0, res_len}, {1'b0, len});
    end
    repeat (3) @(negedge clk);
  endtask : xf

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    ck("ep1 ctl", ep1_ctl, 8'h00);
    ck("rx ctl", rx_ctl, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(3'h0, (s == 3) ? 8'h07 : 8'(s));
      xf(1'b1, 2'h1, 1'b1, 7'h05, 1'b1, 1'b1, in_ans[s]);
    end
    ck("ep1 ctl", ep1_ctl, 8'h0a);
    xf(1'b0, 2'h1, 1'b0, 7'h04, 1'b1, 1'b0, in_ans[0]);
    wr(3'h0, 8'h03);
    ck("ep1 ctl", ep1_ctl, 8'h03);
    xf(1'b1, 2'h1, 1'b0, 7'h05, 1'b1, 1'b0, in_ans[3]);
    ck("ep1 ctl", ep1_ctl, 8'h03);
    xf(1'b1, 2'h1, 1'b0, 7'h05, 1'b1, 1'b1, in_ans[3]);
    ck("ep1 ctl", ep1_ctl, 8'h0e);
    wr(3'h3, 8'h40);
    for (int s = 0; s < 4; s++) begin
      wr(3'h1, 8'(s));
      xf(1'b0, 2'h2, 1'b0, 7'h10, 1'b1, 1'b0, out_ans[s]);
    end
    ck("rx ctl", rx_ctl, 8'h0e);
    ck("rx cnt", {1'b0, rx_cnt}, 8'h30);
    wr(3'h1, 8'h07);
    xf(1'b0, 2'h2, 1'b0, 7'h08, 1'b1, 1'b0, out_ans[3]);
    xf(1'b0, 2'h2, 1'b1, 7'h08, 1'b0, 1'b0, out_ans[0]);
    xf(1'b0, 2'h2, 1'b1, 7'h31, 1'b1, 1'b0, out_ans[0]);
    ck("rx ctl", rx_ctl, 8'h07);
    ck("rx cnt", {1'b0, rx_cnt}, 8'h30);
    wr(3'h1, 8'h32);
    ck("rx ctl", rx_ctl, 8'h02);
    wr(3'h3, 8'h10);
    wr(3'h1, 8'h03);
    wr(3'h1, 8'h83);
    ck("rx ctl", rx_ctl, 8'h83);
    wr(3'h1, 8'h82);
    ck("rx ctl", rx_ctl, 8'h83);
    wr(3'h4, 8'h04);
    wr(3'h2, 8'h03);
    xf(1'b1, 2'h2, 1'b0, 7'h04, 1'b1, 1'b1, in_ans[3]);
    ck("tx ctl", tx_ctl, 8'h0e);
    ck("cop req", {7'h00, cop_req}, 8'h00);
    xf(1'b0, 2'h2, 1'b0, 7'h10, 1'b1, 1'b0, out_ans[3]);
    ck("dl done req", {6'h00, rx_ctl[3], cop_req}, 8'h01);
    cop();
    ck("cop req", {7'h00, cop_req}, 8'h00);
    ck("rx ctl", rx_ctl, 8'h87);
    ck("rx cnt", {1'b0, rx_cnt}, 8'h10);
    xf(1'b0, 2'h2, 1'b1, 7'h08, 1'b1, 1'b0, out_ans[3]);
    ck("rx ctl", rx_ctl, 8'h0a);
    ck("rx cnt", {1'b0, rx_cnt}, 8'h08);
    wr(3'h4, 8'h20);
    ck("tx cnt", {1'b0, tx_cnt}, 8'h20);
    wr(3'h2, 8'h02);
    wr(3'h1, 8'h42);
    ck("rx ctl", rx_ctl, 8'h42);
    ck("cop req", {7'h00, cop_req}, 8'h01);
    wr(3'h2, 8'h01);
    ck("tx ctl", tx_ctl, 8'h02);
    cop();
    ck("tx ctl", tx_ctl, 8'h03);
    xf(1'b1, 2'h2, 1'b0, 7'h20, 1'b1, 1'b1, in_ans[3]);
    ck("ul done req", {6'h00, tx_ctl[3], cop_req}, 8'h01);
    for (int r = 0; r < 2; r++) begin
      wr(3'h0, 8'h0f);
      @(posedge clk);
      usb_rst <= (r == 0);
      frc_rst <= (r == 1);
      @(posedge clk);
      usb_rst <= 1'b0;
      frc_rst <= 1'b0;
      @(negedge clk);
      ck("ep1 ctl", ep1_ctl, 8'h08);
      ck("rx ctl", rx_ctl, 8'h40);
    end
    give_verdict();
  end
endmodule : tb_usb_ep1_tx_ep2_rx_ctrl
